// ===== include/i2c_bridge_pkg.sv
`default_nettype none
package i2c_bridge_pkg;
    // ==========================================
    // Register offsets
    localparam logic [7:0] ADDR_BRIDGE_CONFIG = 8'h05;
    localparam logic [7:0] ADDR_DESER_ADDRESS = 8'h06;
    localparam logic [7:0] ADDR_TARGET_PHYS0 = 8'h07;
    localparam logic [7:0] ADDR_TARGET_ALIAS0 = 8'h08;
    // ==========================================
    // Field positions
    localparam int CFG_WD_DISABLE_BIT = 0;
    localparam int CFG_WD_FAST_BIT = 1;
    localparam int CFG_BLOCK_WR_BIT = 2;
    localparam int CFG_SDA_DLY_LSB = 3;
    localparam int HOLD_ADDR_BIT = 0;
    localparam int ADDR7_LSB = 1;
    // ==========================================
    // Reset values
    localparam logic [4:0] CFG_RESET = 5'h00;
    localparam logic [6:0] ADDR7_RESET = 7'h00;
    localparam logic HOLD_RESET = 1'b0;
    // ==========================================
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int SDA_DLY_BASE_NS = 200;
    localparam int SDA_DLY_STEP_NS = 40;
    localparam int WD_FAST_US = 50;
    localparam int WD_SLOW_S = 1;
    localparam int WD_FAST_CYCLES = (WD_FAST_US * 1000) / CLK_PERIOD_NS;
    localparam int WD_SLOW_CYCLES = (WD_SLOW_S * 1000000000) / CLK_PERIOD_NS;
    localparam int RECOVERY_HALF_US = 5;
    localparam int RECOVERY_HALF_CYCLES = (RECOVERY_HALF_US * 1000) / CLK_PERIOD_NS;
    localparam int RECOVERY_PULSES = 9;
    localparam int WD_CNT_W = 24;

    // Least time, so round up
    function automatic logic [2:0] sda_delay_cycles(input logic [1:0] code);
        int ns;
        ns = SDA_DLY_BASE_NS + SDA_DLY_STEP_NS * int'(code);
        return 3'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    endfunction
endpackage
`default_nettype wire

// ===== include/bus_watchdog_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bus_watchdog_if;
    logic enable;
    logic fast;
    logic scl_s;
    logic sda_s;
    logic bus_free;
    logic scl_pull;
    logic recovering;
    modport ctrl(output enable, output fast, output scl_s, output sda_s,
                 input bus_free, input scl_pull, input recovering);
    modport wd(input enable, input fast, input scl_s, input sda_s,
               output bus_free, output scl_pull, output recovering);
endinterface
`default_nettype wire

// ===== src/bus_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
module bus_watchdog
    import i2c_bridge_pkg::*;
#(
    parameter int SLOW_CYCLES = WD_SLOW_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    bus_watchdog_if.wd w
);
    typedef enum logic [1:0] {WATCH, IDLE_FREE, PULL_LOW, RELEASE} wd_state_e;

    wd_state_e state_q, state_d;
    logic [WD_CNT_W-1:0] cnt_q;
    logic [6:0] half_q;
    logic [3:0] pulses_q;
    logic scl_prev_q, sda_prev_q;

    wire activity = (w.scl_s != scl_prev_q) || (w.sda_s != sda_prev_q);
    wire [WD_CNT_W-1:0] limit = w.fast ? WD_CNT_W'(WD_FAST_CYCLES - 1) : WD_CNT_W'(SLOW_CYCLES - 1);
    wire expired = (cnt_q >= limit);
    wire half_done = (half_q == 7'(RECOVERY_HALF_CYCLES - 1));

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            WATCH: begin
                if (expired && !activity) begin
                    state_d = w.sda_s ? IDLE_FREE : PULL_LOW;
                end
            end
            IDLE_FREE: begin
                if (activity) begin
                    state_d = WATCH;
                end
            end
            PULL_LOW: begin
                if (half_done) begin
                    state_d = RELEASE;
                end
            end
            RELEASE: begin
                if (half_done) begin
                    state_d = (pulses_q == 4'(RECOVERY_PULSES - 1)) ? WATCH : PULL_LOW;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        scl_prev_q <= w.scl_s;
        sda_prev_q <= w.sda_s;
        if (srst || !w.enable) begin
            state_q <= WATCH;
            cnt_q <= '0;
            half_q <= '0;
            pulses_q <= '0;
            w.bus_free <= 1'b0;
            w.scl_pull <= 1'b0;
            w.recovering <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= (activity || state_q != WATCH) ? '0 : (expired ? cnt_q : cnt_q + 1'b1);
            half_q <= (state_q inside {PULL_LOW, RELEASE}) && !half_done ? half_q + 1'b1 : '0;
            if (state_q == WATCH) begin
                pulses_q <= '0;
            end else if (state_q == RELEASE && half_done) begin
                pulses_q <= pulses_q + 1'b1;
            end
            w.bus_free <= (state_d == IDLE_FREE);
            w.scl_pull <= (state_d == PULL_LOW);
            w.recovering <= (state_d inside {PULL_LOW, RELEASE});
        end
    end
endmodule
`default_nettype wire

// ===== src/i2c_bridge_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_bridge_ctrl
    import i2c_bridge_pkg::*;
#(
    parameter int WD_SLOW_CYCLES_P = WD_SLOW_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_from_channel,
    input wire logic second_port_select,
    output logic [7:0] reg_rdata,
    output logic reg_wr_refused,
    input wire logic [1:0] rx_lock,
    input wire logic [1:0] chan_addr_valid,
    input wire logic [6:0] chan_addr_p0,
    input wire logic [6:0] chan_addr_p1,
    input wire logic txn_valid,
    input wire logic txn_port,
    input wire logic [6:0] txn_addr,
    output logic fwd_valid,
    output logic fwd_to_deser,
    output logic [6:0] fwd_addr,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_drive_low,
    output logic scl_out,
    output logic scl_oe_n,
    output logic sda_out,
    output logic sda_oe_n,
    output logic bus_free,
    output logic bus_recovering
);
    // ==========================================
    // Pin synchronisers
    // Left unreset; the reset period flushes them
    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic scl_prev_q;
    always_ff @(posedge clk) begin
        scl_sync_q <= {scl_sync_q[0], scl_in};
        sda_sync_q <= {sda_sync_q[0], sda_in};
        scl_prev_q <= scl_sync_q[1];
    end
    wire scl_s = scl_sync_q[1];
    wire sda_s = sda_sync_q[1];

    // ==========================================
    // Registers
    logic [4:0] cfg_q;
    logic [6:0] deser_addr_q [2];
    logic hold_q [2];
    logic [6:0] phys_q [2];
    logic [6:0] alias_q [2];

    wire port = second_port_select;
    wire hit_cfg = (reg_addr == ADDR_BRIDGE_CONFIG);
    wire hit_deser = (reg_addr == ADDR_DESER_ADDRESS);
    wire hit_phys = (reg_addr == ADDR_TARGET_PHYS0);
    wire hit_alias = (reg_addr == ADDR_TARGET_ALIAS0);
    // Only writes into this register file are gated; passthrough traffic never comes here
    wire wr_blocked = reg_wr && reg_from_channel && cfg_q[CFG_BLOCK_WR_BIT];
    wire wr_ok = reg_wr && !wr_blocked;

    wire [7:0] rd_cfg = {3'h0, cfg_q};
    wire [7:0] rd_deser = {deser_addr_q[port], hold_q[port]};
    wire [7:0] rd_phys = {phys_q[port], 1'b0};
    wire [7:0] rd_alias = {alias_q[port], 1'b0};
    logic [7:0] rd_mux;
    assign rd_mux = hit_cfg ? rd_cfg :
                    hit_deser ? rd_deser :
                    hit_phys ? rd_phys :
                    hit_alias ? rd_alias : 8'h00;

    // Read data lags the address by one cycle

    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_q <= CFG_RESET;
            reg_rdata <= 8'h00;
            reg_wr_refused <= 1'b0;
        end else begin
            reg_rdata <= rd_mux;
            reg_wr_refused <= wr_blocked;
            if (wr_ok && hit_cfg) begin
                cfg_q <= reg_wdata[4:0];
            end
        end
    end

    // ==========================================
    // Per-port copies
    logic [6:0] chan_addr [2];
    assign chan_addr[0] = chan_addr_p0;
    assign chan_addr[1] = chan_addr_p1;

    for (genvar p = 0; p < 2; p++) begin : g_port
        wire sel = (port == 1'(p));
        always_ff @(posedge clk) begin
            if (srst) begin
                deser_addr_q[p] <= ADDR7_RESET;
                hold_q[p] <= HOLD_RESET;
                phys_q[p] <= ADDR7_RESET;
                alias_q[p] <= ADDR7_RESET;
            end else begin
                // Software write wins over a same-cycle channel offer
                if (wr_ok && sel && hit_deser) begin
                    deser_addr_q[p] <= reg_wdata[7:ADDR7_LSB];
                    hold_q[p] <= reg_wdata[HOLD_ADDR_BIT];
                end else if (rx_lock[p] && chan_addr_valid[p] && !hold_q[p]) begin
                    deser_addr_q[p] <= chan_addr[p];
                end
                if (wr_ok && sel && hit_phys) begin
                    phys_q[p] <= reg_wdata[7:ADDR7_LSB];
                end
                if (wr_ok && sel && hit_alias) begin
                    alias_q[p] <= reg_wdata[7:ADDR7_LSB];
                end
            end
        end
    end

    // ==========================================
    // Address remap toward the control channel
    // Zero in a programmed address means no match
    function automatic logic addr_match(input logic [6:0] prog, input logic [6:0] seen);
        return (prog != 7'h00) && (seen == prog);
    endfunction
    wire alias_hit = addr_match(alias_q[txn_port], txn_addr);
    wire deser_hit = addr_match(deser_addr_q[txn_port], txn_addr);
    // Alias wins over a deserializer match; fwd_addr holds between transactions
    always_ff @(posedge clk) begin
        if (srst) begin
            fwd_valid <= 1'b0;
            fwd_to_deser <= 1'b0;
            fwd_addr <= 7'h00;
        end else begin
            fwd_valid <= txn_valid && (alias_hit || deser_hit);
            fwd_to_deser <= deser_hit && !alias_hit;
            if (txn_valid) begin
                fwd_addr <= alias_hit ? phys_q[txn_port] : txn_addr;
            end
        end
    end

    // ==========================================
    // SDA output delay after SCL falls
    logic [2:0] dly_q;
    logic sda_pend_q;
    // A new SCL fall restarts the count, so only the last fall counts
    wire scl_fell = scl_prev_q && !scl_s;
    wire [2:0] dly_target = sda_delay_cycles(cfg_q[CFG_SDA_DLY_LSB +: 2]);
    always_ff @(posedge clk) begin
        if (srst) begin
            dly_q <= 3'h0;
            sda_pend_q <= 1'b0;
            sda_oe_n <= 1'b1;
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            if (scl_fell) begin
                sda_pend_q <= 1'b1;
                dly_q <= 3'h1;
            end else if (sda_pend_q) begin
                dly_q <= dly_q + 3'h1;
            end
            if (sda_pend_q && !scl_fell && dly_q == dly_target) begin
                sda_pend_q <= 1'b0;
                sda_oe_n <= !sda_drive_low;
            end
        end
    end

    // ==========================================
    // Bus watchdog
    // Our own recovery pulses are not counted as bus activity
    bus_watchdog_if wd_bus();
    assign wd_bus.enable = !cfg_q[CFG_WD_DISABLE_BIT];
    assign wd_bus.fast = cfg_q[CFG_WD_FAST_BIT];
    assign wd_bus.scl_s = scl_s;
    assign wd_bus.sda_s = sda_s;

    bus_watchdog #(.SLOW_CYCLES(WD_SLOW_CYCLES_P)) u_watchdog (
        .clk(clk),
        .srst(srst),
        .w(wd_bus.wd)
    );

    // Open drain: output values stay 0, only the enables move
    always_ff @(posedge clk) begin
        if (srst) begin
            scl_out <= 1'b0;
            scl_oe_n <= 1'b1;
            bus_free <= 1'b0;
            bus_recovering <= 1'b0;
        end else begin
            scl_out <= 1'b0;
            scl_oe_n <= !wd_bus.scl_pull;
            bus_free <= wd_bus.bus_free;
            bus_recovering <= wd_bus.recovering;
        end
    end
endmodule
`default_nettype wire

// ===== test/i2c_bridge_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_bridge_monitor
    import i2c_bridge_pkg::*;
#(
    parameter int WD_SLOW_CYCLES_P = WD_SLOW_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_from_channel,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_wr_refused,
    input wire logic txn_valid,
    input wire logic fwd_valid,
    input wire logic [6:0] fwd_addr,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic scl_oe_n,
    input wire logic sda_oe_n,
    input wire logic bus_free,
    input wire logic bus_recovering
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    refuse_cause_a: assert property (reg_wr_refused |-> $past(reg_wr && reg_from_channel))
        else $error("refusal without remote write");
    local_wr_a: assert property (reg_wr && !reg_from_channel |=> !reg_wr_refused)
        else $error("local write refused");
    cfg_reserved_a: assert property ($past(reg_addr) == ADDR_BRIDGE_CONFIG |-> reg_rdata[7:5] == 3'h0)
        else $error("config reserved bits set");
    unmapped_zero_a: assert property ($past(reg_addr) < 8'h05 || $past(reg_addr) > 8'h08 |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    fwd_cause_a: assert property (fwd_valid |-> $past(txn_valid) && fwd_addr != 7'h00)
        else $error("forward without matching transaction");
    sda_delay_a: assert property ($fell(scl_in) |=> $stable(sda_oe_n) [*3])
        else $error("sda changed too soon after scl fall");
    free_sda_a: assert property ($rose(bus_free) |-> sda_in && !bus_recovering)
        else $error("bus free while sda low");
    recover_low_a: assert property ($rose(bus_recovering) |-> !sda_in && !bus_free)
        else $error("recovery while sda high");
    pulse_len_a: assert property (bus_recovering && $fell(scl_oe_n) |-> !scl_oe_n [*8])
        else $error("recovery pulse too short");
    scl_idle_a: assert property (!bus_recovering && !$past(bus_recovering) |-> scl_oe_n)
        else $error("scl pulled outside recovery");
    cover property (reg_wr_refused);
    cover property (fwd_valid);
    cover property ($rose(bus_free));
    cover property ($rose(bus_recovering));
endmodule
bind i2c_bridge_ctrl i2c_bridge_monitor #(.WD_SLOW_CYCLES_P(WD_SLOW_CYCLES_P)) i_mon (.clk(clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_from_channel(reg_from_channel), .reg_rdata(reg_rdata),
    .reg_wr_refused(reg_wr_refused), .txn_valid(txn_valid), .fwd_valid(fwd_valid), .fwd_addr(fwd_addr),
    .scl_in(scl_in), .sda_in(sda_in), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .bus_free(bus_free),
    .bus_recovering(bus_recovering));
`default_nettype wire

// ===== test/i2c_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_model (
    input wire logic scl_oe_n,
    input wire logic sda_oe_n,
    input wire logic ext_scl_low,
    input wire logic ext_sda_low,
    output logic scl,
    output logic sda
);
    // Pull-ups: a released line goes back high
    assign scl = scl_oe_n & !ext_scl_low;
    assign sda = sda_oe_n & !ext_sda_low;
endmodule
`default_nettype wire

// ===== test/test_i2c_bridge_ctrl_config.sv
`timescale 1ns/1ps
`default_nettype none
module test_i2c_bridge_ctrl_config;
    import i2c_bridge_pkg::*;
    logic clk = 0, srst = 1, wr = 0, fch = 0, psel = 0, tv = 0, tp = 0, sdl = 0, xscl = 0, xsda = 0;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
    logic [1:0] lock = 2'h0, cav = 2'h0;
    logic [6:0] ca0 = 7'h00, ca1 = 7'h00, ta = 7'h00, fa;
    logic refused, fv, fd, scl, sda, scl_oe_n, sda_oe_n, bfree, brec, so, sdo;
    int n_fail = 0, check_count = 0;
    logic [7:0] rd_q[$], fw_q[$];
    int ref_q[$];
    event rd_ev;
    i2c_bridge_ctrl #(.WD_SLOW_CYCLES_P(2000)) i_i2c_bridge_ctrl (.clk(clk), .srst(srst), .reg_addr(addr),
        .reg_wdata(wd), .reg_wr(wr), .reg_from_channel(fch), .second_port_select(psel), .reg_rdata(rdata),
        .reg_wr_refused(refused), .rx_lock(lock), .chan_addr_valid(cav), .chan_addr_p0(ca0), .chan_addr_p1(ca1),
        .txn_valid(tv), .txn_port(tp), .txn_addr(ta), .fwd_valid(fv), .fwd_to_deser(fd), .fwd_addr(fa),
        .scl_in(scl), .sda_in(sda), .sda_drive_low(sdl), .scl_out(so), .scl_oe_n(scl_oe_n), .sda_out(sdo),
        .sda_oe_n(sda_oe_n), .bus_free(bfree), .bus_recovering(brec));
    i2c_bus_model i_i2c_bus_model (.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .ext_scl_low(xscl),
        .ext_sda_low(xsda), .scl(scl), .sda(sda));
    initial forever #50 clk = ~clk;
    // ==========================================
    // Helpers
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic test_done;
        if (rd_q.size() + fw_q.size() + ref_q.size() != 0) begin
            n_fail++;
            $display("mismatch queues expected 0 seen %0d", rd_q.size() + fw_q.size() + ref_q.size());
        end
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic ch);
        @(negedge clk);
        addr = a;
        wd = d;
        fch = ch;
        wr = 1;
        @(negedge clk);
        wr = 0;
        fch = 0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        @(negedge clk);
        rd_q.push_back(e);
        ->rd_ev;
    endtask
    task automatic txn(input logic [6:0] a, input logic pt);
        @(negedge clk);
        tv = 1;
        ta = a;
        tp = pt;
        @(negedge clk);
        tv = 0;
    endtask
    task automatic offer(input logic [6:0] a);
        @(negedge clk);
        ca0 = a;
        ca1 = ~a;
        cav = 2'h3;
        @(negedge clk);
        cav = 2'h0;
    endtask
    task automatic scl_blip;
        xscl = 1;
        repeat (5) @(negedge clk);
        xscl = 0;
        repeat (5) @(negedge clk);
    endtask
    function automatic logic cond(int w);
        case (w)
            0: return sda_oe_n === 1'b0;
            1: return bfree === 1'b1;
            default: return brec === 1'b1;
        endcase
    endfunction
    task automatic cnt(input int w, output int n);
        n = 0;
        while (!cond(w)) begin
            @(negedge clk);
            n++;
            if (n > 5000) begin
                $display("mismatch wait %0d expected 1 seen 0", w);
                n_fail++;
                test_done();
            end
        end
    endtask
    // ==========================================
    // Result watcher
    always @(rd_ev) chk("rdata", rd_q.pop_front(), rdata);
    always @(negedge clk) begin
        if (fv === 1'b1) chk("fwd", fw_q.size() > 0 ? fw_q.pop_front() : 8'hxx, {fd, fa});
        if (refused === 1'b1) chk("refused", ref_q.size() > 0 ? ref_q.pop_front() : 0, 1);
    end
    // ==========================================
    // Scenarios
    initial begin
        int n, d0, hits;
        logic [6:0] p, a, d, d2;
        logic prev;
        void'($urandom(31));
        repeat (20) @(negedge clk);
        srst = 0;
        for (int r = 4; r < 10; r++) rd_reg(8'(r), 8'h00);
        wr_reg(8'h05, 8'hff, 0);
        rd_reg(8'h05, 8'h1f);
        ref_q.push_back(1);
        wr_reg(8'h07, 8'hff, 1);
        rd_reg(8'h07, 8'h00);
        p = 7'($urandom_range(1, 126));
        a = p + 7'h01;
        wr_reg(8'h07, {p, 1'b1}, 0);
        rd_reg(8'h07, {p, 1'b0});
        wr_reg(8'h08, {a, 1'b0}, 0);
        fw_q.push_back({1'b0, p});
        txn(a, 1'b0);
        wr_reg(8'h08, 8'h00, 0);
        txn(7'h00, 1'b0);
        wr_reg(8'h05, 8'h01, 0);
        wr_reg(8'h07, 8'h14, 1);
        rd_reg(8'h07, 8'h14);
        lock = 2'h3;
        d = 7'($urandom_range(1, 127));
        offer(d);
        rd_reg(8'h06, {d, 1'b0});
        fw_q.push_back({1'b1, d});
        txn(d, 1'b0);
        d2 = d ^ 7'h40;
        wr_reg(8'h06, {d2, 1'b1}, 0);
        offer(d ^ 7'h21);
        rd_reg(8'h06, {d2, 1'b1});
        psel = 1;
        rd_reg(8'h06, {~(d ^ 7'h21), 1'b0});
        wr_reg(8'h06, 8'h23, 0);
        offer(7'h55);
        rd_reg(8'h06, 8'h23);
        fw_q.push_back({1'b1, 7'h11});
        txn(7'h11, 1'b1);
        psel = 0;
        rd_reg(8'h06, {d2, 1'b1});
        for (int c = 0; c < 4; c++) begin
            wr_reg(8'h05, {3'h0, c[1:0], 3'h1}, 0);
            sdl = 1;
            xscl = 1;
            cnt(0, n);
            if (c == 0) d0 = n;
            else chk("sda delay", (c + 1) / 2, n - d0);
            sdl = 0;
            scl_blip();
            scl_blip();
        end
        wr_reg(8'h05, 8'h02, 0);
        scl_blip();
        cnt(1, n);
        chk("fast free", 1, n >= 490 && n <= 510);
        wr_reg(8'h05, 8'h00, 0);
        scl_blip();
        cnt(1, n);
        chk("slow free", 1, n >= 1990 && n <= 2010);
        wr_reg(8'h05, 8'h02, 0);
        xsda = 1;
        cnt(2, n);
        chk("hung wait", 1, n >= 490 && n <= 510);
        prev = 1;
        hits = 0;
        for (n = 0; n < 2000 && brec === 1'b1; n++) begin
            @(negedge clk);
            if (scl_oe_n === 1'b0 && prev === 1'b1) hits++;
            prev = scl_oe_n;
        end
        chk("recovery pulses", 9, hits);
        wr_reg(8'h05, 8'h03, 0);
        hits = 0;
        for (n = 0; n < 1500; n++) begin
            @(negedge clk);
            if (n == 700) xsda = 0;
            if (brec !== 1'b0 || bfree !== 1'b0) hits++;
        end
        chk("disabled watchdog", 0, hits);
        chk("pin drive level", 2'h0, {so, sdo});
        repeat (5) @(negedge clk);
        test_done();
    end
endmodule
`default_nettype wire
